// ### design/pvc_pkg.sv
// Purpose: Shared constants and carriers for the vector current controller
// Assumes: Signed fixed point, Q1.15 for sin/cos and gains
// Notes:   All timing counts are cycles of the 50 MHz clock
package pvc_pkg;
  // ==========================================================
  // Data widths and fixed point
  localparam int DATA_W        = 16;
  localparam int FRAC_W        = 15;
  localparam int CNT_W         = 16;
  // ==========================================================
  // Constants in Q1.15
  localparam logic signed [15:0] SQRT_2_3  = 16'sh6882; // 0.81650
  localparam logic signed [15:0] SQRT_1_6  = 16'sh3441; // 0.40825
  localparam logic signed [15:0] SQRT_1_2  = 16'sh5A82; // 0.70711
  // ==========================================================
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int CARRIER_NS    = 100_000;
  localparam int DEAD_NS       = 4_000;
  localparam int CLK_NS        = 20;
  // Half period: carrier counts up then down
  localparam int HALF_CYC      = CARRIER_NS / CLK_NS / 2;
  // Least time rounds up
  localparam int DEAD_CYC      = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] RESET_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CLARK = 4'b0010,
    ST_PI    = 4'b0100,
    ST_OUT   = 4'b1000
  } pvc_state_e;

  typedef struct packed {
    logic signed [15:0] phaseU;
    logic signed [15:0] phaseV;
    logic signed [15:0] phaseW;
  } pvc_tri_s;

  typedef struct packed {
    logic signed [15:0] d;
    logic signed [15:0] q;
  } pvc_dq_s;
endpackage

// ### design/pvc_vector_ctrl.sv
// Purpose: Per-carrier vector current control and complementary PWM
// Assumes: Inputs come from logic on the same clock; sin/cos supplied
// Notes:   One computation per carrier period, launched at the trough
`timescale 1ns/1ps
// Contract
// - Phase currents become alpha/beta by the scaled 3-to-2 transform.
// - Alpha/beta rotate by theta into d and q currents.
// - Errors are the commands minus the measured d and q currents.
// - Each axis voltage updates incrementally with P and I terms.
// - d/q voltages rotate back into alpha/beta voltages.
// - Alpha/beta voltages become U, V, W by the scaled 2-to-3 transform.
// - Phase voltages map onto duty values centred on the carrier.
// - Each high-side output is active high while its voltage exceeds the carrier.
// - The carrier period sets one computation and duty update per cycle.
// - Each phase drives a complementary pair separated by dead time.
// - Optional feedforward cancels the cross-coupling of d and q.
// - Currents and angle go in, compare values go to the PWM stage.
// - Compare values load only at the carrier trough.
module pvc_vector_ctrl
  import pvc_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int DEAD = DEAD_CYC
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire pvc_tri_s            phaseCurrent,
  input  wire logic signed [15:0]  sinTheta,
  input  wire logic signed [15:0]  cosTheta,
  input  wire logic signed [15:0]  omega,
  input  wire pvc_dq_s             currentCommand,
  input  wire logic signed [15:0]  proportional_gain,
  input  wire logic signed [15:0]  integral_gain,
  input  wire logic signed [15:0]  direct_axis_inductance,
  input  wire logic signed [15:0]  quadrature_axis_inductance,
  input  wire logic signed [15:0]  magnetFlux,
  input  wire logic                decoupleEn,
  output logic [2:0]               pwmHigh,
  output logic [2:0]               pwmLow,
  output logic [15:0]              carrier,
  output logic                     troughPulse,
  output pvc_tri_s                 compareValue,
  output pvc_dq_s                  axisVoltage
);
  // ==========================================================
  // State
  typedef struct packed {
    pvc_state_e         st;
    logic [15:0]        cnt;
    logic               down;
    logic               trough;
    logic signed [15:0] iAlpha, iBeta;
    pvc_dq_s            iDq;
    pvc_dq_s            err;
    pvc_dq_s            errPrev;
    pvc_dq_s            volt;
    pvc_tri_s           duty;
    pvc_tri_s           dutyNew;
    logic [2:0]         raw;
    logic [47:0]        dtCnt;
    logic [2:0]         hi, lo;
  } pvc_reg_s;

  pvc_reg_s state_reg, state_next;

  function automatic logic signed [15:0] mulq(
    input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    mulq = p[30:15];
  endfunction

  function automatic logic signed [15:0] sat(input logic signed [17:0] x);
    if (x > 18'sh07FFF)       sat = 16'sh7FFF;
    else if (x < -18'sh08000) sat = 16'sh8000;
    else                      sat = x[15:0];
  endfunction

  always_comb
  begin
    logic signed [15:0] vA, vB, ffD, ffQ, vU, vV, vW;
    logic signed [17:0] sumD, sumQ;
    logic signed [31:0] sc;
    logic [15:0]        cmp [3];
    state_next = state_reg;
    vA = '0; vB = '0; ffD = '0; ffQ = '0; vU = '0; vV = '0; vW = '0;
    sumD = '0; sumQ = '0; sc = '0;
    cmp[0] = '0; cmp[1] = '0; cmp[2] = '0;
    state_next.trough = 1'b0;
    // Up/down carrier; trough when counting down reaches zero
    // Both ends of the count stand two cycles, so a period is 2*HALF
    if (state_reg.down)
    begin
      if (state_reg.cnt == 16'h0000)
      begin
        state_next.down   = 1'b0;
        state_next.cnt    = 16'h0000;
        state_next.trough = 1'b1;
        state_next.duty   = state_reg.dutyNew;
      end
      else
        state_next.cnt = state_reg.cnt - 16'h0001;
    end
    else if (state_reg.cnt >= 16'(HALF - 1))
    begin
      state_next.down = 1'b1;
      state_next.cnt  = state_reg.cnt;
    end
    else
      state_next.cnt = state_reg.cnt + 16'h0001;

    case (state_reg.st)
      ST_IDLE:
        if (state_reg.trough)
          state_next.st = ST_CLARK;
      ST_CLARK:
      begin
        // Iw folded in; sqrt(2/3) scaling
        state_next.iAlpha = sat(18'(mulq(SQRT_2_3, phaseCurrent.phaseU))
          - 18'(mulq(SQRT_1_6, phaseCurrent.phaseV))
          - 18'(mulq(SQRT_1_6, phaseCurrent.phaseW)));
        state_next.iBeta  = sat(
          18'(mulq(SQRT_1_2, phaseCurrent.phaseV))
          - 18'(mulq(SQRT_1_2, phaseCurrent.phaseW)));
        state_next.st = ST_PI;
      end
      ST_PI:
      begin
        state_next.iDq.d = sat(18'(mulq(cosTheta, state_reg.iAlpha))
          + 18'(mulq(sinTheta, state_reg.iBeta)));
        state_next.iDq.q = sat(18'(mulq(cosTheta, state_reg.iBeta))
          - 18'(mulq(sinTheta, state_reg.iAlpha)));
        state_next.st = ST_OUT;
      end
      ST_OUT:
      begin
        // d command is the supervisor's, passed through unchanged
        state_next.err.d = sat(18'(currentCommand.d)
          - 18'(state_reg.iDq.d));
        state_next.err.q = sat(18'(currentCommand.q)
          - 18'(state_reg.iDq.q));
        // Sampling interval is folded into the integral gain
        sumD = 18'(state_reg.volt.d)
          + 18'(mulq(proportional_gain,
              sat(18'(state_next.err.d) - 18'(state_reg.errPrev.d))))
          + 18'(mulq(integral_gain, state_next.err.d));
        sumQ = 18'(state_reg.volt.q)
          + 18'(mulq(proportional_gain,
              sat(18'(state_next.err.q) - 18'(state_reg.errPrev.q))))
          + 18'(mulq(integral_gain, state_next.err.q));
        state_next.volt.d = sat(sumD);
        state_next.volt.q = sat(sumQ);
        state_next.errPrev = state_next.err;
        // Feedforward kept out of the PI memory so it cannot wind up
        if (decoupleEn)
        begin
          ffD = -mulq(omega,
            mulq(quadrature_axis_inductance, state_reg.iDq.q));
          ffQ = mulq(omega, sat(
            18'(mulq(direct_axis_inductance, state_reg.iDq.d))
            + 18'(mulq(SQRT_2_3, magnetFlux))));
        end
        vA = sat(18'(mulq(cosTheta, sat(sumD + 18'(ffD))))
          - 18'(mulq(sinTheta, sat(sumQ + 18'(ffQ)))));
        vB = sat(18'(mulq(sinTheta, sat(sumD + 18'(ffD))))
          + 18'(mulq(cosTheta, sat(sumQ + 18'(ffQ)))));
        vU = mulq(SQRT_2_3, vA);
        vV = sat(18'(-mulq(SQRT_1_6, vA))
          + 18'(mulq(SQRT_1_2, vB)));
        vW = sat(18'(-mulq(SQRT_1_6, vA))
          - 18'(mulq(SQRT_1_2, vB)));
        // Full scale maps onto 0..HALF around the carrier midpoint
        sc = 32'(HALF / 2) + ((32'(vU) * 32'(HALF)) >>> 16);
        cmp[0] = sc[15:0];
        sc = 32'(HALF / 2) + ((32'(vV) * 32'(HALF)) >>> 16);
        cmp[1] = sc[15:0];
        sc = 32'(HALF / 2) + ((32'(vW) * 32'(HALF)) >>> 16);
        cmp[2] = sc[15:0];
        state_next.dutyNew = {cmp[0], cmp[1], cmp[2]};
        state_next.st = ST_IDLE;
      end
      default:
        state_next.st = ST_IDLE;
    endcase

    // ========================================================
    // Compare and dead time per phase
    for (int i = 0; i < 3; i++)
    begin
      logic r;
      r = state_reg.duty[16*(2-i) +: 16] > state_reg.cnt;
      state_next.raw[i] = r;
      if (r != state_reg.raw[i])
      begin
        state_next.dtCnt[16*i +: 16] = 16'(DEAD);
        state_next.hi[i] = 1'b0;
        state_next.lo[i] = 1'b0;
      end
      else if (state_reg.dtCnt[16*i +: 16] > 16'h0001)
        state_next.dtCnt[16*i +: 16] =
          state_reg.dtCnt[16*i +: 16] - 16'h0001;
      else
      begin
        state_next.dtCnt[16*i +: 16] = 16'h0000;
        state_next.hi[i] = r;
        state_next.lo[i] = ~r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '{st: ST_IDLE, default: '0};
    else if (clkEn)
      state_reg <= state_next;
  end

  assign pwmHigh      = state_reg.hi;
  assign pwmLow       = state_reg.lo;
  assign carrier      = state_reg.cnt;
  assign troughPulse  = state_reg.trough;
  assign compareValue = state_reg.duty;
  assign axisVoltage  = state_reg.volt;
endmodule

// ### sim/pvc_vector_ctrl_sva.sv
// Purpose: Port properties of the vector current controller
// Assumes: Period counter advances only on enabled cycles
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module pvc_vector_ctrl_sva
  import pvc_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int DEAD = DEAD_CYC
)
(
  input logic        clk,
  input logic        rst_n,
  input logic        clkEn,
  input logic [2:0]  pwmHigh,
  input logic [2:0]  pwmLow,
  input logic [15:0] carrier,
  input logic        troughPulse,
  input pvc_tri_s    compareValue,
  input pvc_dq_s     axisVoltage
);
  localparam int DL = DEAD - 1;
  // ==========================================================
  // Helper: enabled cycles since the last trough
  // A counter stands in for a long delay that the tools would unroll
  logic [15:0] sinceTrough;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sinceTrough <= 16'h0000;
    else if (clkEn)
    begin
      if (troughPulse)
        sinceTrough <= 16'h0001;
      else if (sinceTrough != 16'hFFFF)
        sinceTrough <= sinceTrough + 16'h0001;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_trough_period: assert property (troughPulse |->
    sinceTrough == 16'(2 * HALF)) else $error("bad period");
  a_trough_gap: assert property (sinceTrough <= 16'(2 * HALF))
    else $error("trough missing");
  a_hold_state: assert property (!clkEn |=>
    $stable(carrier) && $stable(compareValue))
    else $error("moved while held");
  a_carrier_step: assert property ($changed(carrier) |->
    carrier == $past(carrier) + 16'h0001 ||
    carrier + 16'h0001 == $past(carrier)) else $error("carrier jump");
  a_load_trough: assert property ($changed(compareValue) |-> troughPulse)
    else $error("duty load off trough");
  a_axis_after: assert property ($changed(axisVoltage) |->
    $past(troughPulse, 2) || $past(troughPulse, 3) || $past(troughPulse, 4))
    else $error("axis update late");
  a_pwm_excl: assert property ((pwmHigh & pwmLow) == 3'b000)
    else $error("pair overlap");
  a_dead_u: assert property ($fell(pwmHigh[0]) |->
    !pwmLow[0] throughout ##DL 1'b1) else $error("dead time short U");
  a_dead_v: assert property ($fell(pwmLow[1]) |->
    !pwmHigh[1] throughout ##DL 1'b1) else $error("dead time short V");
  a_pwm_cmp: assert property (pwmHigh[2] |->
    compareValue.phaseW > carrier ||
    $past(compareValue.phaseW) > $past(carrier))
    else $error("W high below carrier");
  a_reset_zero: assert property ($rose(rst_n) |->
    axisVoltage == '0 && compareValue == '0 && pwmHigh == 3'b000)
    else $error("state not cleared");
endmodule

// ### sim/pvc_motor_side.sv
// Purpose: Current converter and angle source facing the controller
// Assumes: Conversions complete within one clock
// Notes:   Values stand between triggers, as real converters hold them
`timescale 1ns/1ps
module pvc_motor_side
  import pvc_pkg::*;
(
  input logic                clk,
  input logic                rst_n,
  input logic                troughPulse,
  input pvc_tri_s            setCurrent,
  input logic signed [15:0]  setSin,
  input logic signed [15:0]  setCos,
  output pvc_tri_s           phaseCurrent,
  output logic signed [15:0] sinTheta,
  output logic signed [15:0] cosTheta
);
  // Sampling at the trough keeps results clear of the switching edges
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      phaseCurrent <= '0;
      sinTheta     <= '0;
      cosTheta     <= '0;
    end
    else if (troughPulse)
    begin
      phaseCurrent <= setCurrent;
      sinTheta     <= setSin;
      cosTheta     <= setCos;
    end
endmodule

// ### sim/pvc_vector_ctrl_tb.sv
// Purpose: Self-checking bench for the vector current controller
// Assumes: Shortened carrier and dead time
// Notes:   Expected values use exact Q1.15 products or narrow bands
`timescale 1ns/1ps
module pvc_vector_ctrl_tb;
  import pvc_pkg::*;
  localparam int HALF = 20;
  localparam int DEAD = 3;
  localparam logic [15:0] MID = 16'(HALF / 2);
  logic clk = 1'b0, rst_n = 1'b0, troughPulse, decoupleEn, clkEn;
  logic signed [15:0] sinSet, cosSet, omega, kp, ki, ld, lq, flux;
  logic signed [15:0] sinTheta, cosTheta;
  pvc_tri_s iSet, phaseCurrent, compareValue;
  pvc_dq_s cmd, axisVoltage;
  logic [2:0] pwmHigh, pwmLow;
  logic [15:0] carrier;
  int errCount = 0, testsRun = 0;
  always #10 clk = ~clk;
  pvc_vector_ctrl #(.HALF(HALF), .DEAD(DEAD)) pvc_vector_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .phaseCurrent(phaseCurrent),
    .sinTheta(sinTheta), .cosTheta(cosTheta), .omega(omega),
    .currentCommand(cmd), .proportional_gain(kp), .integral_gain(ki),
    .direct_axis_inductance(ld), .quadrature_axis_inductance(lq),
    .magnetFlux(flux), .decoupleEn(decoupleEn), .pwmHigh(pwmHigh),
    .pwmLow(pwmLow), .carrier(carrier), .troughPulse(troughPulse),
    .compareValue(compareValue), .axisVoltage(axisVoltage));
  pvc_motor_side pvc_motor_side_inst (.clk(clk), .rst_n(rst_n),
    .troughPulse(troughPulse), .setCurrent(iSet), .setSin(sinSet),
    .setCos(cosSet), .phaseCurrent(phaseCurrent), .sinTheta(sinTheta),
    .cosTheta(cosTheta));
  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task stopTest;
    $display("Counts: %0d compared, %0d wrong", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Waits n troughs, then lets the PI update land
  task waitT(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        #1;
        k++;
      end
      while (troughPulse !== 1'b1 && k < 100);
      chk("trough", 16'h0001, {15'h0000, troughPulse});
    end
    repeat (5) @(posedge clk);
  endtask
  task doReset(input logic signed [15:0] p, input logic signed [15:0] i);
    @(posedge clk);
    rst_n <= 1'b0;
    kp <= p;
    ki <= i;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // ==========================================================
  // Scenarios
  task testZero;
    int hi;
    int lo;
    doReset(16'h4000, 16'h0800);
    waitT(2);
    chk("vd", 16'h0000, axisVoltage.d);
    chk("vq", 16'h0000, axisVoltage.q);
    chk("dutyV", MID, compareValue.phaseV);
    chk("dutyW", MID, compareValue.phaseW);
    repeat (HALF) @(posedge clk);
    hi = 0;
    lo = 0;
    repeat (2 * HALF)
    begin
      @(posedge clk);
      #1;
      hi += pwmHigh[0];
      lo += pwmLow[0];
    end
    chk("highCnt", 16'(HALF - DEAD), 16'(hi));
    chk("lowCnt", 16'(HALF - DEAD), 16'(lo));
    $display("testZero done");
  endtask
  task testQ;
    doReset(16'h4000, 16'h0000);
    cmd <= '{d: 16'h0000, q: 16'h2000};
    waitT(2);
    chk("vq", 16'h1000, axisVoltage.q);
    chk("vd", 16'h0000, axisVoltage.d);
    chk("dutyU", MID, compareValue.phaseU);
    chk("vAboveW", 16'h0001,
      {15'h0000, compareValue.phaseV > compareValue.phaseW});
    ki <= 16'h0800;
    waitT(1);
    chk("vqInt", 16'h1200, axisVoltage.q);
    cmd <= '0;
    $display("testQ done");
  endtask
  task testMeas;
    doReset(16'h4000, 16'h0000);
    iSet <= '{phaseU: 16'h2000, phaseV: 16'hF000, phaseW: 16'hF000};
    waitT(1);
    chk("vdBand", 16'h0001, {15'h0000, axisVoltage.d inside
      {[-16'sh13A0 : -16'sh1390]}});
    sinSet <= 16'h7FFF;
    cosSet <= 16'h0000;
    waitT(1);
    chk("vqBand", 16'h0001, {15'h0000, axisVoltage.q inside
      {[16'sh1390 : 16'sh13A0]}});
    chk("vdBack", 16'h0001, {15'h0000, axisVoltage.d inside
      {[-16'sh0004 : 16'sh0004]}});
    iSet <= '0;
    sinSet <= 16'h0000;
    cosSet <= 16'h7FFF;
    $display("testMeas done");
  endtask
  task testFf;
    doReset(16'h0000, 16'h0000);
    decoupleEn <= 1'b1;
    waitT(2);
    chk("vqState", 16'h0000, axisVoltage.q);
    chk("ffU", MID, compareValue.phaseU);
    chk("ffV", 16'h0001,
      {15'h0000, compareValue.phaseV > compareValue.phaseW});
    decoupleEn <= 1'b0;
    waitT(2);
    chk("offV", MID, compareValue.phaseV);
    $display("testFf done");
  endtask
  // Freezes the block for eleven edges, then lets it run on
  task testHold;
    logic [15:0] held;
    waitT(1);
    clkEn <= 1'b0;
    @(posedge clk);
    held = carrier;
    repeat (10) @(posedge clk);
    chk("heldCarrier", held, carrier);
    chk("heldDuty", MID, compareValue.phaseU);
    clkEn <= 1'b1;
    waitT(1);
    chk("resumeDuty", MID, compareValue.phaseU);
    $display("testHold done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {decoupleEn, kp, ki, sinSet, iSet, cmd} = '0;
    {omega, flux, ld, lq} = {16'h2000, 16'h2000, 16'h1000, 16'h1000};
    cosSet = 16'h7FFF;
    clkEn = 1'b1;
    testZero();
    testQ();
    testMeas();
    testFf();
    testHold();
    stopTest();
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    errCount++;
    $display("Error watchdog expired");
    stopTest();
  end
endmodule
bind pvc_vector_ctrl pvc_vector_ctrl_sva #(.HALF(HALF), .DEAD(DEAD))
  pvc_vector_ctrl_sva_inst (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
  .pwmHigh(pwmHigh), .pwmLow(pwmLow), .carrier(carrier),
  .troughPulse(troughPulse),
  .compareValue(compareValue), .axisVoltage(axisVoltage));
